// ==== src/acl_pkg.sv ====
package acl_pkg;
	// =====================================================
	// Widths and register map
	localparam int CW = 32;
	localparam int AW = 5;
	localparam int QDEPTH = 3;
	localparam logic [AW-1:0] A_CTRL = 5'h00;
	localparam logic [AW-1:0] A_PLIM = 5'h01;
	localparam logic [AW-1:0] A_NLIM = 5'h02;
	localparam logic [AW-1:0] A_TOL = 5'h03;
	localparam logic [AW-1:0] A_GCFG = 5'h04;
	localparam logic [AW-1:0] A_GVAL = 5'h05;
	localparam logic [AW-1:0] A_TCFG = 5'h06;
	localparam logic [AW-1:0] A_TVAL = 5'h07;
	localparam logic [AW-1:0] A_SPD_REM = 5'h08;
	localparam logic [AW-1:0] A_SPD_OLD = 5'h09;
	localparam logic [AW-1:0] A_SPD_NEW = 5'h0A;
	localparam logic [AW-1:0] A_SPD_ACC = 5'h0B;
	localparam logic [AW-1:0] A_CMD = 5'h0C;
	localparam logic [AW-1:0] A_GROUP = 5'h0D;
	localparam logic [AW-1:0] A_CMPDATA = 5'h0E;
	localparam logic [AW-1:0] A_CMPSTS = 5'h0F;
	localparam logic [AW-1:0] A_LATCH = 5'h10;
	localparam logic [AW-1:0] A_EVT = 5'h11;
	// =====================================================
	// Field positions and codes
	localparam int EVT_PLIM = 0;
	localparam int EVT_NLIM = 1;
	localparam int EVT_OOS = 10;
	localparam int EVT_GCMP = 11;
	localparam int EVT_TCMP = 12;
	localparam int GRP_START = 0;
	localparam int GRP_STOP = 1;
	localparam logic [2:0] M_EQ = 3'h1;
	localparam logic [2:0] M_EQ_POS = 3'h2;
	localparam logic [2:0] M_EQ_NEG = 3'h3;
	localparam logic [2:0] M_GT = 3'h4;
	localparam logic [2:0] M_LT = 3'h5;
	localparam logic [1:0] ACT_IMM = 2'h1;
	localparam logic [1:0] ACT_DEC = 2'h2;
	localparam logic [1:0] ACT_SPD = 2'h3;
	localparam logic [1:0] SYNC_GROUP = 2'h1;
	localparam logic [1:0] SYNC_MASK = 2'h3;
	localparam logic [CW-1:0] VAL_RST = 32'h0;
	localparam logic [2:0] CMPSEL_RST = 3'h1;
	// =====================================================
	// Carriers
	typedef struct packed {
		logic [3:0] wait_mask;
		logic [1:0] sync_start;
		logic stop_decel;
		logic sync_stop_on;
		logic conti_en;
		logic reload_fifo;
		logic auto_src;
		logic trig_idle;
		logic [1:0] latch_src;
		logic [2:0] latch_cnt;
		logic latch_edge;
		logic oos_en;
		logic [1:0] limit_action;
		logic soft_limit_en;
	} acl_ctrl_t;
	typedef struct packed {
		logic [1:0] action;
		logic [2:0] method;
		logic [1:0] src;
	} acl_cmp_cfg_t;
	typedef struct packed {
		logic [CW-1:0] acc_time;
		logic [CW-1:0] new_vel;
		logic [CW-1:0] old_vel;
		logic [CW-1:0] rem_dist;
	} acl_spd_t;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} acl_state_t;
	localparam acl_ctrl_t CTRL_RST = '0;
	localparam acl_cmp_cfg_t CFG_RST = '0;
endpackage : acl_pkg

// ==== src/acl_axis_event.sv ====
`timescale 1ns/100ps
// Functional notes
// - Axes 2,3 latch edge: 0 rise, 1 fall
// - Latched counter select 1..4, readable
// - Soft limit action: int, stop, decelerate
// - Separate positive and negative soft limits
// - Out-of-step enable and tolerance value
// - Error over tolerance sets event bit 10
// - Comparator source select codes 0..3
// - Comparator methods 0..5
// - General comparator action codes 0..3
// - Trigger idles high at 0, low at 1
// - Compare value readable by selector 1..5
// - Status word, one bit per comparator
// - Auto compare off or from FIFO
// - Reload from host RAM or FIFO
// - Comparator speed change with stored values
// - Latch source: pin, cmp4, cmp5, origin
// - Queue status 0..3 occupancy
// - Waiting axis starts on group start
// - Stop-all drives group stop line
// - Stop by programmed stop mode
// - Stop mode 0 immediate, 1 decelerate
// - Start can wait for other axes
// - Wait mask bits per axis, all stopped
module acl_axis_event import acl_pkg::*; #(
	parameter int AXIS_ID = 0
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [AW-1:0] ADDR,
	input wire logic [CW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [CW-1:0] RDATA,
	input wire logic signed [CW-1:0] CMD_CNT,
	input wire logic signed [CW-1:0] FB_CNT,
	input wire logic signed [CW-1:0] ERR_CNT,
	input wire logic signed [CW-1:0] GP_CNT,
	input wire logic LATCH_IN,
	input wire logic ORIGIN_INPUT,
	input wire logic STOP_IN,
	input wire logic MOTION_DONE,
	input wire logic [3:0] AXES_STOPPED,
	input wire logic FIFO_VALID,
	input wire logic signed [CW-1:0] FIFO_DATA,
	output logic FIFO_POP,
	output logic TRIG_OUT,
	output logic MOVE_START,
	output logic [CW-1:0] CMD_OUT,
	output logic STOP_IMM,
	output logic STOP_DEC,
	output logic SPD_CHG,
	output acl_spd_t SPD_PARAMS,
	output logic EVENT_PENDING,
	input wire logic GROUP_START_LINE_IN,
	output logic GROUP_START_LINE_OUT,
	output logic GROUP_START_LINE_OE,
	input wire logic GROUP_STOP_LINE_IN,
	output logic GROUP_STOP_LINE_OUT,
	output logic GROUP_STOP_LINE_OE
);
	localparam bit HAS_EDGE = (AXIS_ID >= 2);
	localparam bit HAS_TRIG = (AXIS_ID < 2);

	// =====================================================
	// Registers
	acl_ctrl_t ctrl_reg;
	acl_cmp_cfg_t gcfg_reg, tcfg_reg;
	acl_spd_t spd_reg;
	logic signed [CW-1:0] plim_reg, nlim_reg, tol_reg, gval_reg, tval_reg;
	logic signed [CW-1:0] gprev_reg, tprev_reg, latch_reg;
	logic [CW-1:0] q_reg [QDEPTH];
	logic [1:0] occ_reg;
	logic [2:0] cmpsel_reg;
	logic [4:0] sts_reg;
	logic [15:0] evt_reg;
	logic lat_prev_reg, org_prev_reg, gs_reg, gp_reg;
	acl_state_t state_reg;

	function automatic logic signed [CW-1:0] pick(input logic [1:0] s,
		input logic signed [CW-1:0] c0, c1, c2, c3);
		unique case (s)
			2'h0: pick = c0;
			2'h1: pick = c1;
			2'h2: pick = c2;
			2'h3: pick = c3;
		endcase
	endfunction : pick

	// Directional equality variants (M_EQ_POS, M_EQ_NEG) fire once, on arrival, not while parked; M_EQ holds while parked
	function automatic logic cmp_hit(input logic [2:0] m,
		input logic signed [CW-1:0] s, p, v);
		case (m)
			M_EQ: cmp_hit = (s == v);
			M_EQ_POS: cmp_hit = (s == v) && (s > p);
			M_EQ_NEG: cmp_hit = (s == v) && (s < p);
			M_GT: cmp_hit = (v > s);
			M_LT: cmp_hit = (v < s);
			default: cmp_hit = 1'b0;
		endcase
	endfunction : cmp_hit

	// =====================================================
	// Comparators
	logic signed [CW-1:0] gsrc, tsrc, tval, err_abs;
	logic auto_fifo, pl_hit, nl_hit, e_hit, g_hit, t_hit;
	logic [4:0] hits, rise;
	assign gsrc = pick(gcfg_reg.src, CMD_CNT, FB_CNT, ERR_CNT, GP_CNT);
	assign tsrc = pick(tcfg_reg.src, CMD_CNT, FB_CNT, ERR_CNT, GP_CNT);
	assign auto_fifo = ctrl_reg.auto_src && ctrl_reg.reload_fifo;
	// host rewrites the value when not from FIFO
	assign tval = auto_fifo ? FIFO_DATA : tval_reg;
	assign err_abs = ERR_CNT[CW-1] ? -ERR_CNT : ERR_CNT;
	// each limit judged on its own
	assign pl_hit = ctrl_reg.soft_limit_en && (CMD_CNT >= plim_reg);
	assign nl_hit = ctrl_reg.soft_limit_en && (CMD_CNT <= nlim_reg);
	assign e_hit = ctrl_reg.oos_en && (err_abs > tol_reg);
	assign g_hit = cmp_hit(gcfg_reg.method, gsrc, gprev_reg, gval_reg);
	assign t_hit = HAS_TRIG && cmp_hit(tcfg_reg.method, tsrc, tprev_reg, tval)
		&& (!auto_fifo || FIFO_VALID);
	assign hits = {t_hit, g_hit, e_hit, nl_hit, pl_hit};
	assign rise = hits & ~sts_reg;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			sts_reg <= '0;
			gprev_reg <= '0;
			tprev_reg <= '0;
		end else begin
			sts_reg <= hits;
			gprev_reg <= gsrc;
			tprev_reg <= tsrc;
		end
	end

	// =====================================================
	// Stop and speed requests
	logic ext_stop, lim_rise, stop_imm_req, stop_dec_req, stop_any;
	assign ext_stop = STOP_IN || (GROUP_STOP_LINE_IN && ctrl_reg.sync_stop_on);
	assign lim_rise = rise[0] || rise[1];
	assign stop_imm_req = (lim_rise && ctrl_reg.limit_action == ACT_IMM)
		|| (rise[3] && gcfg_reg.action == ACT_IMM)
		|| (ext_stop && !ctrl_reg.stop_decel);
	assign stop_dec_req = (lim_rise && ctrl_reg.limit_action == ACT_DEC)
		|| (rise[3] && gcfg_reg.action == ACT_DEC)
		|| (ext_stop && ctrl_reg.stop_decel);
	assign stop_any = stop_imm_req || stop_dec_req;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			STOP_IMM <= 1'b0;
			STOP_DEC <= 1'b0;
			SPD_CHG <= 1'b0;
			SPD_PARAMS <= '0;
		end else begin
			STOP_IMM <= stop_imm_req;
			STOP_DEC <= stop_dec_req && !stop_imm_req;
			SPD_CHG <= rise[3] && gcfg_reg.action == ACT_SPD;
			if (rise[3] && gcfg_reg.action == ACT_SPD) begin
				SPD_PARAMS <= spd_reg;
			end
		end
	end

	// =====================================================
	// Trigger output and FIFO
	// pulse is the opposite of the idle level
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			TRIG_OUT <= 1'b1;
			FIFO_POP <= 1'b0;
		end else begin
			TRIG_OUT <= ~ctrl_reg.trig_idle ^ rise[4];
			FIFO_POP <= rise[4] && auto_fifo;
		end
	end

	// =====================================================
	// Latch
	logic lat_ev;
	logic signed [CW-1:0] lat_val;
	// edge choice only on axes 2 and 3
	always_comb begin
		lat_ev = 1'b0;
		unique case (ctrl_reg.latch_src)
			2'h0: lat_ev = (HAS_EDGE && ctrl_reg.latch_edge) ?
				(lat_prev_reg && !LATCH_IN) : (!lat_prev_reg && LATCH_IN);
			2'h1: lat_ev = rise[3];
			2'h2: lat_ev = rise[4];
			2'h3: lat_ev = !org_prev_reg && ORIGIN_INPUT;
		endcase
	end
	assign lat_val = pick(2'(ctrl_reg.latch_cnt - 3'h1), CMD_CNT, FB_CNT, ERR_CNT,
		GP_CNT);

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			lat_prev_reg <= 1'b0;
			org_prev_reg <= 1'b0;
			latch_reg <= '0;
		end else begin
			lat_prev_reg <= LATCH_IN;
			org_prev_reg <= ORIGIN_INPUT;
			if (lat_ev) begin
				latch_reg <= lat_val;
			end
		end
	end

	// =====================================================
	// Command queue and start sequencing
	logic start_ok, wr_cmd, pop;
	logic [1:0] occ_after;
	always_comb begin
		unique case (ctrl_reg.sync_start)
			SYNC_GROUP: start_ok = GROUP_START_LINE_IN;
			SYNC_MASK: start_ok = (AXES_STOPPED & ctrl_reg.wait_mask) == ctrl_reg.wait_mask;
			default: start_ok = 1'b1;
		endcase
	end
	// writes to a full queue are dropped
	assign wr_cmd = WR && ADDR == A_CMD &&
		(ctrl_reg.conti_en ? occ_reg != 2'h3 : occ_reg == 2'h0);
	assign pop = state_reg == ST_RUN && MOTION_DONE;
	assign occ_after = occ_reg - 2'(pop);

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_reg <= ST_IDLE;
			occ_reg <= '0;
			MOVE_START <= 1'b0;
			CMD_OUT <= '0;
			for (int i = 0; i < QDEPTH; i++) begin
				q_reg[i] <= '0;
			end
		end else begin
			MOVE_START <= 1'b0;
			if (pop) begin
				q_reg[0] <= q_reg[1];
				q_reg[1] <= q_reg[2];
			end
			if (wr_cmd) begin
				q_reg[occ_after] <= WDATA;
			end
			occ_reg <= occ_after + 2'(wr_cmd);
			unique case (state_reg)
				ST_IDLE: begin
					if (occ_reg != 2'h0) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (stop_any) begin
						state_reg <= ST_IDLE;
						occ_reg <= '0;
					end else if (start_ok) begin
						MOVE_START <= 1'b1;
						CMD_OUT <= q_reg[0];
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (stop_any) begin
						occ_reg <= 2'h1;
					end
					if (pop) begin
						if (ctrl_reg.conti_en && occ_reg > 2'h1 && !stop_any) begin
							MOVE_START <= 1'b1;
							CMD_OUT <= q_reg[1];
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// =====================================================
	// Register writes and group lines
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ctrl_reg <= CTRL_RST;
			gcfg_reg <= CFG_RST;
			tcfg_reg <= CFG_RST;
			plim_reg <= VAL_RST;
			nlim_reg <= VAL_RST;
			tol_reg <= VAL_RST;
			gval_reg <= VAL_RST;
			tval_reg <= VAL_RST;
			spd_reg <= '0;
			cmpsel_reg <= CMPSEL_RST;
		end else if (WR) begin
			unique case (ADDR)
				A_CTRL: ctrl_reg <= acl_ctrl_t'(WDATA[$bits(acl_ctrl_t)-1:0]);
				A_PLIM: plim_reg <= WDATA;
				A_NLIM: nlim_reg <= WDATA;
				A_TOL: tol_reg <= WDATA;
				A_GCFG: gcfg_reg <= acl_cmp_cfg_t'(WDATA[$bits(acl_cmp_cfg_t)-1:0]);
				A_GVAL: gval_reg <= WDATA;
				A_TCFG: tcfg_reg <= acl_cmp_cfg_t'(WDATA[$bits(acl_cmp_cfg_t)-1:0]);
				A_TVAL: tval_reg <= WDATA;
				A_SPD_REM: spd_reg.rem_dist <= WDATA;
				A_SPD_OLD: spd_reg.old_vel <= WDATA;
				A_SPD_NEW: spd_reg.new_vel <= WDATA;
				A_SPD_ACC: spd_reg.acc_time <= WDATA;
				A_CMPDATA: cmpsel_reg <= WDATA[2:0];
				default: ;
			endcase
		end
	end

	// one-cycle drive of the shared lines
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			gs_reg <= 1'b0;
			gp_reg <= 1'b0;
		end else begin
			gs_reg <= WR && ADDR == A_GROUP && WDATA[GRP_START];
			gp_reg <= WR && ADDR == A_GROUP && WDATA[GRP_STOP];
		end
	end
	assign GROUP_START_LINE_OUT = gs_reg;
	assign GROUP_START_LINE_OE = gs_reg;
	assign GROUP_STOP_LINE_OUT = gp_reg;
	assign GROUP_STOP_LINE_OE = gp_reg;

	// =====================================================
	// Events, set wins over write-one-clear
	logic [15:0] evt_set;
	always_comb begin
		evt_set = '0;
		evt_set[EVT_PLIM] = rise[0];
		evt_set[EVT_NLIM] = rise[1];
		evt_set[EVT_OOS] = rise[2];
		evt_set[EVT_GCMP] = rise[3];
		evt_set[EVT_TCMP] = rise[4];
	end
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			evt_reg <= '0;
			EVENT_PENDING <= 1'b0;
		end else begin
			evt_reg <= (evt_reg & ~((WR && ADDR == A_EVT) ? WDATA[15:0] : 16'h0)) | evt_set;
			EVENT_PENDING <= |evt_reg;
		end
	end

	// =====================================================
	// Read port
	logic [CW-1:0] rd_mux, cmp_data;
	always_comb begin
		unique case (cmpsel_reg)
			3'h1: cmp_data = plim_reg;
			3'h2: cmp_data = nlim_reg;
			3'h3: cmp_data = tol_reg;
			3'h4: cmp_data = gval_reg;
			3'h5: cmp_data = tval;
			default: cmp_data = '0;
		endcase
	end
	always_comb begin
		unique case (ADDR)
			A_CTRL: rd_mux = CW'(ctrl_reg);
			A_PLIM: rd_mux = plim_reg;
			A_NLIM: rd_mux = nlim_reg;
			A_TOL: rd_mux = tol_reg;
			A_GCFG: rd_mux = CW'(gcfg_reg);
			A_GVAL: rd_mux = gval_reg;
			A_TCFG: rd_mux = CW'(tcfg_reg);
			A_TVAL: rd_mux = tval_reg;
			A_CMD: rd_mux = CW'(occ_reg);
			A_CMPDATA: rd_mux = cmp_data;
			A_CMPSTS: rd_mux = CW'(sts_reg);
			A_LATCH: rd_mux = latch_reg;
			A_EVT: rd_mux = CW'(evt_reg);
			default: rd_mux = '0;
		endcase
	end
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			RDATA <= '0;
		end else begin
			RDATA <= RD ? rd_mux : '0;
		end
	end

	// =====================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_latch_rise;
		ctrl_reg.latch_src == 2'h0 && !ctrl_reg.latch_edge && !lat_prev_reg && LATCH_IN
		|=> latch_reg == $past(lat_val);
	endproperty
	a_latch_rise: assert property (p_latch_rise) else $error("latch missed");
	property p_lim_stop;
		lim_rise && ctrl_reg.limit_action == ACT_IMM |=> STOP_IMM;
	endproperty
	a_lim_stop: assert property (p_lim_stop) else $error("no limit stop");
	property p_oos;
		ctrl_reg.oos_en && err_abs > tol_reg && !sts_reg[2] |=> evt_reg[EVT_OOS];
	endproperty
	a_oos: assert property (p_oos) else $error("out-of-step lost");
	property p_gt;
		gcfg_reg.method == M_GT && gval_reg > gsrc |=> sts_reg[3];
	endproperty
	a_gt: assert property (p_gt) else $error("method 4 wrong");
	property p_trig;
		TRIG_OUT == ctrl_reg.trig_idle |-> $past(rise[4]) || $past(ctrl_reg) != ctrl_reg;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger level");
	property p_pop;
		rise[4] && auto_fifo |=> FIFO_POP ##1 !FIFO_POP;
	endproperty
	a_pop: assert property (p_pop) else $error("fifo pop");
	property p_hold;
		state_reg == ST_WAIT && ctrl_reg.sync_start == SYNC_GROUP && !GROUP_START_LINE_IN
		|=> !MOVE_START;
	endproperty
	a_hold: assert property (p_hold) else $error("early start");
	property p_mask;
		state_reg == ST_WAIT && ctrl_reg.sync_start == SYNC_MASK && start_ok && !stop_any
		|=> MOVE_START && state_reg == ST_RUN;
	endproperty
	a_mask: assert property (p_mask) else $error("mask start");
	property p_gstop;
		WR && ADDR == A_GROUP && WDATA[GRP_STOP] |=> GROUP_STOP_LINE_OE;
	endproperty
	a_gstop: assert property (p_gstop) else $error("no stop drive");
	c_start: cover property (MOVE_START);
	c_latch: cover property (lat_ev);
	c_spd: cover property (SPD_CHG);
endmodule : acl_axis_event

// ==== test/acl_drive_model.sv ====
`timescale 1ns/100ps
// ==========================================
// Motor drive and remote board model
module acl_drive_model import acl_pkg::*; #(
	parameter int DONE_DLY = 20
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic move_start,
	input wire logic [CW-1:0] cmd_out,
	input wire logic stop_imm,
	input wire logic stop_dec,
	input wire logic spd_chg,
	input wire acl_spd_t spd_params,
	input wire logic start_out,
	input wire logic start_oe,
	input wire logic stop_out,
	input wire logic stop_oe,
	input wire logic other_busy,
	output logic motion_done,
	output logic [3:0] axes_stopped,
	output logic start_line,
	output logic stop_line
);
	int n_start;
	int n_imm;
	int n_dec;
	int n_spd;
	int busy;
	logic [CW-1:0] last_cmd;
	acl_spd_t spd_cap;
	// Other boards stay released here
	logic remote_start = 1'b0;
	logic remote_stop = 1'b0;
	assign start_line = (start_out & start_oe) | remote_start;
	assign stop_line = (stop_out & stop_oe) | remote_stop;
	// axis 1 held busy by the bench
	assign axes_stopped = {2'h3, !other_busy, busy == 0};
	// ==========================================
	// Motion, stops and speed change
	always @(posedge clk) begin
		motion_done <= 1'b0;
		if (!rstn) begin
			n_start <= 0;
			n_imm <= 0;
			n_dec <= 0;
			n_spd <= 0;
			busy <= 0;
		end else begin
			if (move_start) begin
				n_start <= n_start + 1;
				last_cmd <= cmd_out;
				busy <= DONE_DLY;
			end else if (busy == 1) begin
				motion_done <= 1'b1;
				busy <= 0;
			end else if (busy > 1) begin
				busy <= busy - 1;
			end
			if (stop_imm | stop_dec) begin
				busy <= 0;
				motion_done <= busy != 0;
			end
			n_imm <= n_imm + int'(stop_imm);
			n_dec <= n_dec + int'(stop_dec);
			if (spd_chg) begin
				n_spd <= n_spd + 1;
				spd_cap <= spd_params;
			end
		end
	end
endmodule : acl_drive_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb import acl_pkg::*;;
	localparam logic [CW-1:0] ALL = 32'hFFFFFFFF;
	localparam logic [AW-1:0] CA [5] = '{A_PLIM, A_NLIM, A_TOL, A_GVAL, A_TVAL};
	localparam logic [2:0] MT [8] = '{M_EQ_POS, M_EQ_NEG, M_EQ_NEG, M_GT, M_LT, M_LT, 3'h0, M_EQ};
	localparam int DS [8] = '{-1, -1, 1, 0, 0, 0, -1, 1};
	localparam int DE [8] = '{0, 0, 0, -1, 1, -1, 0, 0};
	localparam logic [7:0] HIT = 8'h9D;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [AW-1:0] addr = 5'h00;
	logic [CW-1:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_q = 1'b0;
	logic origin = 1'b0;
	logic stop_in = 1'b0;
	logic latch = 1'b0;
	logic other_busy = 1'b0;
	logic fifo_valid = 1'b0;
	logic [CW-1:0] fifo_data = 32'h0;
	logic fpop, evp;
	int n_pop = 0;
	int n_trig = 0;
	int n0;
	logic signed [CW-1:0] cnt [4] = '{default: 32'h0};
	logic [CW-1:0] rdata;
	logic [CW-1:0] cmd_out;
	logic [3:0] stopped;
	logic done, trig, mstart, s_imm, s_dec, spd_chg, st_out, st_oe, sp_out, sp_oe, st_ln, sp_ln;
	acl_spd_t spd;
	int fails = 0;
	int total_checks = 0;
	int seed = 57120;
	logic [CW-1:0] exp_q [$];
	logic [CW-1:0] v;
	logic [CW-1:0] sv [4];
	logic [CW-1:0] cv [5];

	always #12.5 clk = ~clk;

	acl_axis_event #(.AXIS_ID(0)) i_acl_axis_event (.CLK(clk), .RSTN(rstn), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CMD_CNT(cnt[0]), .FB_CNT(cnt[1]),
		.ERR_CNT(cnt[2]), .GP_CNT(cnt[3]), .LATCH_IN(latch), .ORIGIN_INPUT(origin),
		.STOP_IN(stop_in), .MOTION_DONE(done), .AXES_STOPPED(stopped), .FIFO_VALID(fifo_valid),
		.FIFO_DATA(fifo_data), .FIFO_POP(fpop), .TRIG_OUT(trig), .MOVE_START(mstart),
		.CMD_OUT(cmd_out), .STOP_IMM(s_imm), .STOP_DEC(s_dec), .SPD_CHG(spd_chg),
		.SPD_PARAMS(spd), .EVENT_PENDING(evp), .GROUP_START_LINE_IN(st_ln),
		.GROUP_START_LINE_OUT(st_out), .GROUP_START_LINE_OE(st_oe),
		.GROUP_STOP_LINE_IN(sp_ln), .GROUP_STOP_LINE_OUT(sp_out), .GROUP_STOP_LINE_OE(sp_oe));

	acl_drive_model #(.DONE_DLY(20)) i_acl_drive_model (.clk(clk), .rstn(rstn),
		.move_start(mstart), .cmd_out(cmd_out), .stop_imm(s_imm), .stop_dec(s_dec),
		.spd_chg(spd_chg), .spd_params(spd), .start_out(st_out), .start_oe(st_oe),
		.stop_out(sp_out), .stop_oe(sp_oe), .motion_done(done), .axes_stopped(stopped),
		.start_line(st_ln), .stop_line(sp_ln), .other_busy(other_busy));

	// ==========================================
	// Shared tasks
	task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [AW-1:0] a, input logic [CW-1:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [AW-1:0] a, input logic [CW-1:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rreg
	task automatic put(input int k, input logic [CW-1:0] d);
		@(posedge clk);
		cnt[k] <= d;
	endtask : put
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	// Read data stands one cycle only
	always @(posedge clk) begin
		if (rd_q) begin
			chk(rdata, exp_q.pop_front());
		end
		rd_q <= rd;
	end

	// FIFO head advances on each pop; trigger cycles counted
	always @(posedge clk) begin
		n_pop <= n_pop + int'(fpop);
		n_trig <= n_trig + int'(!trig);
		if (fpop) begin
			fifo_data <= fifo_data + 32'h10;
		end
	end

	initial begin
		idle(5000);
		fails++;
		wrap_up();
	end

	// ==========================================
	// Scenarios
	initial begin
		idle(4);
		rstn <= 1'b1;
		rreg(A_CTRL, 32'h0);
		rreg(A_CMD, 32'h0);
		rreg(A_CMPDATA, VAL_RST);
		rreg(5'h1F, 32'h0);
		#2 chk({31'h0, trig}, 32'h1);
		for (int k = 0; k < 5; k++) begin
			cv[k] = $random(seed);
			wreg(CA[k], cv[k]);
		end
		for (int k = 0; k < 5; k++) begin
			wreg(A_CMPDATA, 32'(k + 1));
			rreg(A_CMPDATA, cv[k]);
		end
		wreg(A_PLIM, 32'h7FFFFFFF);
		wreg(A_NLIM, 32'h80000000);
		wreg(A_TOL, 32'h7FFFFFFF);
		for (int k = 0; k < 4; k++) begin
			sv[k] = $random(seed);
			wreg(A_SPD_REM + AW'(k), sv[k]);
		end
		v = $random(seed) & 32'h0FFFFFFF;
		wreg(A_GVAL, v);
		for (int k = 0; k < 4; k++) put(k, v - 7);
		for (int s = 0; s < 4; s++) begin
			wreg(A_GCFG, {25'h0, 2'(s), M_EQ, 2'(s)});
			put(s, v);
			idle(2);
			rreg(A_CMPSTS, 32'h8);
			put(s, v - 7);
		end
		rreg(A_EVT, 32'h800);
		chk(i_acl_drive_model.n_imm, 32'h1);
		chk(i_acl_drive_model.n_dec, 32'h1);
		for (int k = 0; k < 4; k++) chk(i_acl_drive_model.spd_cap[k*CW +: CW], sv[k]);
		for (int k = 0; k < 8; k++) begin
			put(0, v + DS[k]);
			wreg(A_GCFG, {27'h0, MT[k], 2'h0});
			wreg(A_EVT, ALL);
			put(0, v + DE[k]);
			idle(2);
			rreg(A_EVT, HIT[k] ? 32'h800 : 32'h0);
		end
		wreg(A_GCFG, 32'h0);
		put(0, 32'h0);
		wreg(A_PLIM, 32'h64);
		wreg(A_NLIM, 32'hFFFFFF9C);
		wreg(A_EVT, ALL);
		wreg(A_CTRL, 32'h3);
		put(0, 32'h64);
		idle(2);
		rreg(A_EVT, 32'h1);
		wreg(A_CTRL, 32'h5);
		put(0, 32'hFFFFFF9C);
		idle(2);
		rreg(A_EVT, 32'h3);
		chk(i_acl_drive_model.n_imm, 32'h2);
		chk(i_acl_drive_model.n_dec, 32'h2);
		put(0, 32'h0);
		wreg(A_CTRL, 32'h0);
		wreg(A_PLIM, 32'h7FFFFFFF);
		wreg(A_NLIM, 32'h80000000);
		put(2, 32'h33);
		wreg(A_TOL, 32'h32);
		wreg(A_EVT, ALL);
		idle(2);
		rreg(A_EVT, 32'h0);
		put(2, 32'h32);
		wreg(A_CTRL, 32'h8);
		idle(2);
		rreg(A_EVT, 32'h0);
		put(2, 32'h33);
		idle(2);
		rreg(A_EVT, 32'h400);
		chk({31'h0, evp}, 32'h1);
		wreg(A_CTRL, 32'h400);
		rreg(A_CTRL, 32'h400);
		#2 chk({31'h0, trig}, 32'h0);
		wreg(A_CTRL, 32'h340);
		put(1, v);
		@(posedge clk) origin <= 1'b1;
		idle(2);
		rreg(A_LATCH, v);
		wreg(A_CTRL, 32'h20);
		put(0, cv[0]);
		@(posedge clk) latch <= 1'b1;
		idle(2);
		rreg(A_LATCH, cv[0]);
		wreg(A_CTRL, 32'h2000);
		for (int k = 0; k < 3; k++) wreg(A_CMD, 32'hA0 + 32'(k));
		rreg(A_CMD, 32'h3);
		idle(90);
		rreg(A_CMD, 32'h0);
		chk(i_acl_drive_model.n_start, 32'h3);
		chk(i_acl_drive_model.last_cmd, 32'hA2);
		wreg(A_CTRL, 32'h14000);
		wreg(A_CMD, 32'hB0);
		idle(8);
		chk(i_acl_drive_model.n_start, 32'h3);
		wreg(A_GROUP, 32'h1);
		idle(4);
		chk(i_acl_drive_model.n_start, 32'h4);
		@(posedge clk) stop_in <= 1'b1;
		@(posedge clk) stop_in <= 1'b0;
		idle(3);
		chk(i_acl_drive_model.n_imm, 32'h3);
		wreg(A_CTRL, 32'hC000);
		wreg(A_CMD, 32'hC0);
		idle(4);
		wreg(A_GROUP, 32'h2);
		idle(4);
		chk(i_acl_drive_model.n_dec, 32'h3);
		idle(4);
		chk(i_acl_drive_model.last_cmd, 32'hC0);
		@(posedge clk) other_busy <= 1'b1;
		wreg(A_CTRL, 32'hB0000);
		wreg(A_CMD, 32'hD0);
		idle(8);
		chk(i_acl_drive_model.n_start, 32'h5);
		@(posedge clk) other_busy <= 1'b0;
		idle(4);
		chk(i_acl_drive_model.n_start, 32'h6);
		chk(i_acl_drive_model.last_cmd, 32'hD0);
		@(posedge clk) fifo_data <= v + 32'h5;
		fifo_valid <= 1'b1;
		wreg(A_CTRL, 32'h1800);
		wreg(A_TCFG, {27'h0, M_EQ, 2'h1});
		rreg(A_CMPDATA, v + 32'h5);
		n0 = n_trig;
		put(1, v + 32'h5);
		idle(3);
		chk(32'(n_trig - n0), 32'h1);
		chk(32'(n_pop), 32'h1);
		rreg(A_CMPDATA, v + 32'h15);
		rreg(A_EVT, 32'h1400);
		idle(4);
		wrap_up();
	end
endmodule : tb
